// [design/mq_device.sv]
// Message queue port unit: two PCI queue ports over four queues in memory.
// Assumes one requester at a time on the port side and a memory that acks.
//
// Contract
// - Inbound port write stores at post head
// - Advance inbound post head after store
// - Each inbound post raises processor interrupt
// - Retry inbound writes while store pending
// - Full inbound post queue retries, no store
// - Software reads and advances inbound post tail
// - Inbound port read returns free-tail word, advances
// - Empty inbound free read returns all ones
// - Software fills inbound free, advances head
// - Outbound port read returns post-tail word, advances
// - Empty outbound post read: ones, tail kept
// - PCI interrupt while outbound post nonempty
// - Outbound mask bit suppresses PCI interrupt
// - Software posts outbound, advances its head
// - Outbound port write stores at free head
// - Retry outbound writes while store pending
// - Outbound free full raises processor interrupt
// - Full outbound free queue retries, no store
// - Software takes outbound free, advances tail
// - Four equal queues laid out contiguously
// - One-word entries, 4K to 64K per queue
// - Pointers wrap at the queue size
// - Port bursts disconnect after first word
`timescale 1ns/10ps
module mq_device (
	input wire logic CLOCK,
	input wire logic SYS_RST,
	mq_if.dev Q,
	output logic MEM_REQ,
	output logic MEM_WE,
	output logic [31:0] MEM_ADDR,
	output logic [31:0] MEM_WDATA,
	input wire logic MEM_ACK,
	input wire logic [31:0] MEM_RDATA
);
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WR = 2'b01,
		ST_RD = 2'b10
	} state_e;

	state_e state_r;
	logic [31:0] base_r;
	logic [2:0] size_r;
	logic mask_r;
	logic [18:0] qbytes;
	logic [17:0] ptr [8];
	logic [17:0] nxt [8];
	logic [7:0] load_v;
	logic [7:0] inc_v;
	logic [2:0] hw_idx_r;
	logic burst_r;
	logic done_r;
	logic retry_r;
	logic disc_r;
	logic [31:0] rdata_r;
	logic [31:0] reg_rdata_r;
	logic post_irq_r;
	logic full_chk_r;
	logic full_irq_r;
	logic inta_r;
	logic take;
	logic ip_full;
	logic of_full;
	logic if_empty;
	logic op_empty;

	assign qbytes = mq_pkg::queue_bytes(size_r);

	function automatic logic [31:0] q_addr(input logic [1:0] q, input logic [17:0] p);
		logic [31:0] s;
		logic [31:0] off;
		s = {13'h0000, qbytes};
		case (q)
			mq_pkg::Q_IN_FREE: off = 32'h00000000;
			mq_pkg::Q_IN_POST: off = s;
			mq_pkg::Q_OUT_POST: off = s << 1;
			default: off = s + (s << 1);
		endcase
		q_addr = base_r + off + {14'h0000, p};
	endfunction

	function automatic logic [31:0] reg_view(input logic [3:0] sel);
		logic [31:0] v;
		v = 32'h00000000;
		if (sel[3]) begin
			v = {14'h0000, ptr[sel[2:0]]};
		end else begin
			case (sel)
				mq_pkg::RS_BASE: v = base_r;
				mq_pkg::RS_SIZE: v = {29'h00000000, size_r};
				mq_pkg::RS_MASK: v = {31'h00000000, mask_r};
				default: v = 32'h00000000;
			endcase
		end
		reg_view = v;
	endfunction

	// Software may move only the pointers it owns; the others ignore writes.
	for (genvar i = 0; i < 8; i++) begin : g_ptr
		assign load_v[i] = Q.reg_we && (Q.reg_sel == (mq_pkg::RS_PTR + 4'(i)))
			&& mq_pkg::SW_OWNED[i];
		queue_pointer u_ptr (
			.clk(CLOCK),
			.rst(SYS_RST),
			.load(load_v[i]),
			.load_val(Q.reg_wdata[17:0]),
			.inc(inc_v[i]),
			.limit(qbytes),
			.ptr(ptr[i]),
			.ptr_next(nxt[i])
		);
	end

	// One slot is always left empty so that full and empty stay distinct.
	assign ip_full = nxt[mq_pkg::P_IP_HEAD] == ptr[mq_pkg::P_IP_TAIL];
	assign of_full = nxt[mq_pkg::P_OF_HEAD] == ptr[mq_pkg::P_OF_TAIL];
	assign if_empty = ptr[mq_pkg::P_IF_HEAD] == ptr[mq_pkg::P_IF_TAIL];
	assign op_empty = ptr[mq_pkg::P_OP_HEAD] == ptr[mq_pkg::P_OP_TAIL];

	// An answer pulse blocks a new take, so a held request is never taken twice.
	assign take = Q.pci_req && !done_r && !retry_r;

	assign inc_v = (state_r != ST_IDLE && MEM_ACK) ? (8'h01 << hw_idx_r) : 8'h00;

	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			state_r <= ST_IDLE;
			MEM_REQ <= 1'b0;
			MEM_WE <= 1'b0;
			MEM_ADDR <= 32'h00000000;
			MEM_WDATA <= 32'h00000000;
			hw_idx_r <= 3'h0;
			burst_r <= 1'b0;
			done_r <= 1'b0;
			retry_r <= 1'b0;
			disc_r <= 1'b0;
			rdata_r <= 32'h00000000;
		end else begin
			done_r <= 1'b0;
			retry_r <= 1'b0;
			disc_r <= 1'b0;
			case (state_r)
				ST_IDLE: begin
					if (take && Q.pci_write) begin
						if (Q.pci_port == mq_pkg::PORT_OUT ? of_full : ip_full) begin
							retry_r <= 1'b1;
						end else begin
							MEM_REQ <= 1'b1;
							MEM_WE <= 1'b1;
							MEM_WDATA <= Q.pci_wdata;
							if (Q.pci_port == mq_pkg::PORT_OUT) begin
								MEM_ADDR <= q_addr(mq_pkg::Q_OUT_FREE, ptr[mq_pkg::P_OF_HEAD]);
								hw_idx_r <= mq_pkg::P_OF_HEAD;
							end else begin
								MEM_ADDR <= q_addr(mq_pkg::Q_IN_POST, ptr[mq_pkg::P_IP_HEAD]);
								hw_idx_r <= mq_pkg::P_IP_HEAD;
							end
							done_r <= 1'b1;
							disc_r <= Q.pci_burst;
							state_r <= ST_WR;
						end
					end else if (take) begin
						if (Q.pci_port == mq_pkg::PORT_OUT ? op_empty : if_empty) begin
							rdata_r <= mq_pkg::ALL_ONES;
							done_r <= 1'b1;
							disc_r <= Q.pci_burst;
						end else begin
							MEM_REQ <= 1'b1;
							MEM_WE <= 1'b0;
							burst_r <= Q.pci_burst;
							if (Q.pci_port == mq_pkg::PORT_OUT) begin
								MEM_ADDR <= q_addr(mq_pkg::Q_OUT_POST, ptr[mq_pkg::P_OP_TAIL]);
								hw_idx_r <= mq_pkg::P_OP_TAIL;
							end else begin
								MEM_ADDR <= q_addr(mq_pkg::Q_IN_FREE, ptr[mq_pkg::P_IF_TAIL]);
								hw_idx_r <= mq_pkg::P_IF_TAIL;
							end
							state_r <= ST_RD;
						end
					end
				end
				ST_WR: begin
					if (take) begin
						retry_r <= 1'b1;
					end
					if (MEM_ACK) begin
						MEM_REQ <= 1'b0;
						state_r <= ST_IDLE;
					end
				end
				ST_RD: begin
					if (MEM_ACK) begin
						MEM_REQ <= 1'b0;
						rdata_r <= MEM_RDATA;
						done_r <= 1'b1;
						disc_r <= burst_r;
						state_r <= ST_IDLE;
					end
				end
				default: begin
					MEM_REQ <= 1'b0;
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			post_irq_r <= 1'b0;
			full_chk_r <= 1'b0;
			full_irq_r <= 1'b0;
			inta_r <= 1'b0;
		end else begin
			post_irq_r <= inc_v[mq_pkg::P_IP_HEAD];
			full_chk_r <= inc_v[mq_pkg::P_OF_HEAD];
			full_irq_r <= full_chk_r && of_full;
			inta_r <= !op_empty && !mask_r;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			base_r <= mq_pkg::BASE_RST;
			size_r <= mq_pkg::SIZE_RST;
			mask_r <= mq_pkg::MASK_RST;
		end else if (Q.reg_we) begin
			case (Q.reg_sel)
				mq_pkg::RS_BASE: base_r <= Q.reg_wdata;
				mq_pkg::RS_SIZE: size_r <= Q.reg_wdata[2:0];
				mq_pkg::RS_MASK: mask_r <= Q.reg_wdata[0];
				default: base_r <= base_r;
			endcase
		end
	end

	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			reg_rdata_r <= 32'h00000000;
		end else begin
			reg_rdata_r <= reg_view(Q.reg_sel);
		end
	end

	assign Q.pci_done = done_r;
	assign Q.pci_retry = retry_r;
	assign Q.pci_disc = disc_r;
	assign Q.pci_rdata = rdata_r;
	assign Q.reg_rdata = reg_rdata_r;
	assign Q.cpu_post_irq = post_irq_r;
	assign Q.cpu_full_irq = full_irq_r;
	assign Q.pci_inta = inta_r;
endmodule // mq_device

// [design/mq_host.sv]
// Agent end: software on AHB-Lite issues port accesses and register writes.
// Assumes it is the only slave on its bus, so HREADY follows HREADYOUT.
`timescale 1ns/10ps
module mq_host (
	input wire logic CLOCK,
	input wire logic SYS_RST,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic HREADYOUT,
	output logic [31:0] HRDATA,
	output logic HRESP,
	mq_if.host Q
);
	logic a_act_r;
	logic a_wr_r;
	logic [7:0] a_addr_r;
	logic [2:0] pc_ctrl_r;
	logic [31:0] pc_wdata_r;
	logic [31:0] pc_rdata_r;
	logic busy_r;
	logic retry_r;
	logic disc_r;
	logic post_st_r;
	logic full_st_r;
	logic [3:0] rc_sel_r;
	logic [31:0] rc_wdata_r;
	logic reg_we_r;
	logic [31:0] status;

	function automatic logic wr_hit(input logic [7:0] off);
		wr_hit = a_act_r && a_wr_r && (a_addr_r == off);
	endfunction

	// Only whole-word single transfers are expected, so HSIZE is not decoded.
	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			a_act_r <= 1'b0;
			a_wr_r <= 1'b0;
			a_addr_r <= 8'h00;
		end else if (HREADY) begin
			a_act_r <= HSEL && HTRANS[1];
			a_wr_r <= HWRITE;
			a_addr_r <= HADDR[7:0];
		end
	end

	// A new port access while one is open is dropped; software polls busy first.
	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			pc_ctrl_r <= 3'h0;
			busy_r <= 1'b0;
			retry_r <= 1'b0;
			disc_r <= 1'b0;
			pc_rdata_r <= 32'h00000000;
		end else if (wr_hit(mq_pkg::A_PCI_CTRL) && !busy_r) begin
			pc_ctrl_r <= HWDATA[2:0];
			busy_r <= 1'b1;
		end else if (busy_r && (Q.pci_done || Q.pci_retry)) begin
			busy_r <= 1'b0;
			retry_r <= Q.pci_retry;
			disc_r <= Q.pci_disc;
			if (Q.pci_done && !pc_ctrl_r[mq_pkg::PC_WRITE]) begin
				pc_rdata_r <= Q.pci_rdata;
			end
		end
	end

	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			pc_wdata_r <= 32'h00000000;
			rc_wdata_r <= 32'h00000000;
			rc_sel_r <= 4'h0;
			reg_we_r <= 1'b0;
		end else begin
			reg_we_r <= wr_hit(mq_pkg::A_REG_CTRL) && HWDATA[mq_pkg::RC_WRITE];
			if (wr_hit(mq_pkg::A_PCI_WDATA)) begin
				pc_wdata_r <= HWDATA;
			end
			if (wr_hit(mq_pkg::A_REG_WDATA)) begin
				rc_wdata_r <= HWDATA;
			end
			if (wr_hit(mq_pkg::A_REG_CTRL)) begin
				rc_sel_r <= HWDATA[3:0];
			end
		end
	end

	// A new interrupt event in the clearing cycle keeps its bit set.
	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			post_st_r <= 1'b0;
			full_st_r <= 1'b0;
		end else begin
			post_st_r <= Q.cpu_post_irq || (post_st_r && !(wr_hit(mq_pkg::A_STATUS) && HWDATA[mq_pkg::ST_POST]));
			full_st_r <= Q.cpu_full_irq || (full_st_r && !(wr_hit(mq_pkg::A_STATUS) && HWDATA[mq_pkg::ST_FULL]));
		end
	end

	assign status = {26'h0000000, full_st_r, post_st_r, Q.pci_inta, disc_r, retry_r, busy_r};

	always_comb begin
		HRDATA = 32'h00000000;
		if (a_act_r && !a_wr_r) begin
			case (a_addr_r)
				mq_pkg::A_PCI_CTRL: HRDATA = {29'h00000000, pc_ctrl_r};
				mq_pkg::A_PCI_WDATA: HRDATA = pc_wdata_r;
				mq_pkg::A_PCI_RDATA: HRDATA = pc_rdata_r;
				mq_pkg::A_STATUS: HRDATA = status;
				mq_pkg::A_REG_CTRL: HRDATA = {28'h0000000, rc_sel_r};
				mq_pkg::A_REG_WDATA: HRDATA = rc_wdata_r;
				mq_pkg::A_REG_RDATA: HRDATA = Q.reg_rdata;
				default: HRDATA = 32'h00000000;
			endcase
		end
	end

	assign HREADYOUT = 1'b1;
	assign HRESP = 1'b0;
	assign Q.pci_req = busy_r;
	assign Q.pci_write = pc_ctrl_r[mq_pkg::PC_WRITE];
	assign Q.pci_port = pc_ctrl_r[mq_pkg::PC_PORT];
	assign Q.pci_burst = pc_ctrl_r[mq_pkg::PC_BURST];
	assign Q.pci_wdata = pc_wdata_r;
	assign Q.reg_we = reg_we_r;
	assign Q.reg_sel = rc_sel_r;
	assign Q.reg_wdata = rc_wdata_r;
endmodule // mq_host

// [design/mq_if.sv]
// Link between the queue port unit and the agent that drives it.
// Both ends share one clock; nothing here is registered.
`timescale 1ns/10ps
interface mq_if;
	logic pci_req;
	logic pci_write;
	logic pci_port;
	logic pci_burst;
	logic [31:0] pci_wdata;
	logic pci_done;
	logic pci_retry;
	logic pci_disc;
	logic [31:0] pci_rdata;
	logic reg_we;
	logic [3:0] reg_sel;
	logic [31:0] reg_wdata;
	logic [31:0] reg_rdata;
	logic cpu_post_irq;
	logic cpu_full_irq;
	logic pci_inta;

	modport dev (
		input pci_req, pci_write, pci_port, pci_burst, pci_wdata, reg_we, reg_sel, reg_wdata,
		output pci_done, pci_retry, pci_disc, pci_rdata, reg_rdata, cpu_post_irq, cpu_full_irq, pci_inta
	);
	modport host (
		output pci_req, pci_write, pci_port, pci_burst, pci_wdata, reg_we, reg_sel, reg_wdata,
		input pci_done, pci_retry, pci_disc, pci_rdata, reg_rdata, cpu_post_irq, cpu_full_irq, pci_inta
	);
endinterface

// [design/mq_pkg.sv]
// Shared constants for the message queue port unit and its host end.
// Assumes a single core clock; pointers are byte offsets inside one queue.
package mq_pkg;
	localparam int unsigned DW = 32;
	localparam int unsigned PW = 18;
	localparam logic [31:0] ALL_ONES = 32'hffffffff;
	// One queue of the smallest size, in bytes: 4K entries of one word each.
	localparam logic [18:0] QBYTES_MIN = 19'h04000;
	localparam logic [2:0] QSIZE_MAX_SEL = 3'h4;
	localparam logic [18:0] WORD_STEP = 19'h00004;
	// Queue index inside the region, in address order.
	localparam logic [1:0] Q_IN_FREE = 2'h0;
	localparam logic [1:0] Q_IN_POST = 2'h1;
	localparam logic [1:0] Q_OUT_POST = 2'h2;
	localparam logic [1:0] Q_OUT_FREE = 2'h3;
	// Pointer index: twice the queue index, plus one for the tail.
	localparam logic [2:0] P_IF_HEAD = 3'h0;
	localparam logic [2:0] P_IF_TAIL = 3'h1;
	localparam logic [2:0] P_IP_HEAD = 3'h2;
	localparam logic [2:0] P_IP_TAIL = 3'h3;
	localparam logic [2:0] P_OP_HEAD = 3'h4;
	localparam logic [2:0] P_OP_TAIL = 3'h5;
	localparam logic [2:0] P_OF_HEAD = 3'h6;
	localparam logic [2:0] P_OF_TAIL = 3'h7;
	// Pointers that software moves; the rest move only in hardware.
	localparam logic [7:0] SW_OWNED = 8'h99;
	localparam logic PORT_IN = 1'b0;
	localparam logic PORT_OUT = 1'b1;
	// Device register selects.
	localparam logic [3:0] RS_BASE = 4'h0;
	localparam logic [3:0] RS_SIZE = 4'h1;
	localparam logic [3:0] RS_MASK = 4'h2;
	localparam logic [3:0] RS_PTR = 4'h8;
	localparam logic [31:0] BASE_RST = 32'h00000000;
	localparam logic [2:0] SIZE_RST = 3'h0;
	localparam logic MASK_RST = 1'b1;
	// Host register byte offsets on AHB-Lite.
	localparam logic [7:0] A_PCI_CTRL = 8'h00;
	localparam logic [7:0] A_PCI_WDATA = 8'h04;
	localparam logic [7:0] A_PCI_RDATA = 8'h08;
	localparam logic [7:0] A_STATUS = 8'h0c;
	localparam logic [7:0] A_REG_CTRL = 8'h10;
	localparam logic [7:0] A_REG_WDATA = 8'h14;
	localparam logic [7:0] A_REG_RDATA = 8'h18;
	localparam int PC_WRITE = 0;
	localparam int PC_PORT = 1;
	localparam int PC_BURST = 2;
	localparam int ST_BUSY = 0;
	localparam int ST_RETRY = 1;
	localparam int ST_DISC = 2;
	localparam int ST_INTA = 3;
	localparam int ST_POST = 4;
	localparam int ST_FULL = 5;
	localparam int RC_WRITE = 8;

	function automatic logic [18:0] queue_bytes(input logic [2:0] sel);
		queue_bytes = QBYTES_MIN << ((sel > QSIZE_MAX_SEL) ? QSIZE_MAX_SEL : sel);
	endfunction
endpackage

// [design/queue_pointer.sv]
// One head or tail pointer of a circular queue, as a byte offset.
// Assumes load and inc never both fire, since one party owns each pointer.
`timescale 1ns/10ps
module queue_pointer (
	input wire logic clk,
	input wire logic rst,
	input wire logic load,
	input wire logic [17:0] load_val,
	input wire logic inc,
	input wire logic [18:0] limit,
	output logic [17:0] ptr,
	output logic [17:0] ptr_next
);
	logic [18:0] sum;

	assign sum = {1'b0, ptr} + mq_pkg::WORD_STEP;
	// Comparing with >= also recovers a pointer left beyond a queue that was shrunk.
	assign ptr_next = (sum >= limit) ? 18'h00000 : sum[17:0];

	always_ff @(posedge clk) begin
		if (rst) begin
			ptr <= 18'h00000;
		end else if (load) begin
			ptr <= load_val;
		end else if (inc) begin
			ptr <= ptr_next;
		end
	end
endmodule // queue_pointer

// [testbench/message_queue_port_unit_bench.sv]
// Bench: AHB-Lite software drives the host end, which drives the queue unit over mq_if.
// Assumes a memory that acks after a fixed latency, long enough to catch pending stores.
`timescale 1ns/10ps
module message_queue_port_unit_bench;
	localparam logic [31:0] BASE = 32'h00100000;
	localparam logic [31:0] QS = 32'h00004000;
	logic clk, rst, hsel, hwrite, hready, rdy_s, mem_req, mem_we;
	logic mem_ack = 1'b0;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata, rd_s, mem_addr, mem_wdata, v, st;
	logic [31:0] mem_rdata = 32'h0;
	logic [31:0] mem [logic [31:0]];
	int errors = 0;
	int n_checks = 0;
	int stores = 0;
	int wait_n = 0;
	int lat = 40;
	mq_if q();
	mq_host u_mq_host (.CLOCK(clk), .SYS_RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
		.HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready), .HREADYOUT(hready),
		.HRDATA(hrdata), .HRESP(), .Q(q.host));
	mq_device u_mq_device (.CLOCK(clk), .SYS_RST(rst), .Q(q.dev), .MEM_REQ(mem_req), .MEM_WE(mem_we),
		.MEM_ADDR(mem_addr), .MEM_WDATA(mem_wdata), .MEM_ACK(mem_ack), .MEM_RDATA(mem_rdata));
	mq_chk u_mq_chk (.CLOCK(clk), .SYS_RST(rst), .pci_req(q.pci_req), .pci_write(q.pci_write),
		.pci_port(q.pci_port), .pci_burst(q.pci_burst), .pci_done(q.pci_done), .pci_retry(q.pci_retry),
		.pci_disc(q.pci_disc), .pci_rdata(q.pci_rdata), .reg_we(q.reg_we), .reg_sel(q.reg_sel),
		.reg_wdata(q.reg_wdata), .reg_rdata(q.reg_rdata), .cpu_post_irq(q.cpu_post_irq),
		.cpu_full_irq(q.cpu_full_irq), .pci_inta(q.pci_inta));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// Memory: read data lines toggle when idle so a stale word is never mistaken for an answer.
	always @(posedge clk) begin
		mem_ack <= 1'b0;
		mem_rdata <= ~mem_rdata;
		rd_s <= hrdata;
		rdy_s <= hready;
		if (mem_req && !mem_ack) begin
			if (wait_n < lat) wait_n <= wait_n + 1;
			else begin
				wait_n <= 0;
				mem_ack <= 1'b1;
				if (mem_we) begin
					mem[mem_addr] = mem_wdata;
					stores <= stores + 1;
				end else mem_rdata <= mem.exists(mem_addr) ? mem[mem_addr] : 32'h0;
			end
		end
	end
	task conclude;
		if (errors == 0 && n_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Waits for an edge with hready high; signals change just after that edge.
	task rdy;
		int i;
		i = 0;
		do begin
			@(posedge clk);
			#1;
			i++;
		end while (rdy_s !== 1'b1 && i < 20);
		if (rdy_s !== 1'b1) begin
			errors++;
			conclude();
		end
	endtask
	task ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		hsize <= 3'h2;
		rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		rdy();
		r = rd_s;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		ahb(1'b1, a, d, v);
	endtask
	task rd(input logic [7:0] a, output logic [31:0] r);
		ahb(1'b0, a, 32'h0, r);
	endtask
	task regw(input logic [3:0] s, input logic [31:0] d);
		wr(mq_pkg::A_REG_WDATA, d);
		wr(mq_pkg::A_REG_CTRL, {23'h0, 1'b1, 4'h0, s});
		repeat (4) rdy();
	endtask
	task regr(input logic [3:0] s, output logic [31:0] r);
		wr(mq_pkg::A_REG_CTRL, {28'h0, s});
		repeat (3) rdy();
		rd(mq_pkg::A_REG_RDATA, r);
	endtask
	// Control bits: burst, port, write. Leaves the final status word in st.
	task pci(input logic [2:0] c, input logic [31:0] d, output logic [31:0] r);
		int i;
		wr(mq_pkg::A_PCI_WDATA, d);
		wr(mq_pkg::A_PCI_CTRL, {29'h0, c});
		i = 0;
		do begin
			rd(mq_pkg::A_STATUS, st);
			i++;
		end while (st[mq_pkg::ST_BUSY] !== 1'b0 && i < 100);
		if (st[mq_pkg::ST_BUSY] !== 1'b0) begin
			errors++;
			conclude();
		end
		rd(mq_pkg::A_PCI_RDATA, r);
	endtask
	task idle;
		int i;
		for (i = 0; i < 300 && mem_req !== 1'b0; i++)
			rdy();
		if (mem_req !== 1'b0) begin
			errors++;
			conclude();
		end
		repeat (4) rdy();
	endtask
	initial begin
		rst = 1'b1;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h0;
		hwdata = 32'h0;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		rdy();
		regr(mq_pkg::RS_BASE, v);
		chk(v, 32'h0);
		regr(mq_pkg::RS_MASK, v);
		chk(32'(v[0]), 32'h1);
		regw(mq_pkg::RS_BASE, BASE);
		regw(mq_pkg::RS_MASK, 32'h0);
		pci(3'b000, 32'h0, v);
		chk(v, 32'hffffffff);
		pci(3'b001, 32'h0000a5a1, v);
		pci(3'b001, 32'h0000a5a2, v);
		chk(32'(st[mq_pkg::ST_RETRY]), 32'h1);
		idle();
		chk(mem[BASE + QS], 32'h0000a5a1);
		regr(4'ha, v);
		chk(v, 32'h4);
		rd(mq_pkg::A_STATUS, st);
		chk(32'(st[mq_pkg::ST_POST]), 32'h1);
		regw(4'hb, 32'h8);
		pci(3'b001, 32'h0000a5a3, v);
		chk(32'(st[mq_pkg::ST_RETRY]), 32'h1);
		idle();
		chk(stores, 32'h1);
		mem[BASE] = 32'h0000beef;
		regw(4'h8, 32'h4);
		pci(3'b000, 32'h0, v);
		chk(v, 32'h0000beef);
		regr(4'h9, v);
		chk(v, 32'h4);
		pci(3'b100, 32'h0, v);
		chk(v, 32'hffffffff);
		chk(32'(st[mq_pkg::ST_DISC]), 32'h1);
		mem[BASE + 2 * QS] = 32'h0000f00d;
		regw(4'hc, 32'h4);
		rd(mq_pkg::A_STATUS, st);
		chk(32'(st[mq_pkg::ST_INTA]), 32'h1);
		regw(mq_pkg::RS_MASK, 32'h1);
		rd(mq_pkg::A_STATUS, st);
		chk(32'(st[mq_pkg::ST_INTA]), 32'h0);
		regw(mq_pkg::RS_MASK, 32'h0);
		pci(3'b010, 32'h0, v);
		chk(v, 32'h0000f00d);
		rd(mq_pkg::A_STATUS, st);
		chk(32'(st[mq_pkg::ST_INTA]), 32'h0);
		pci(3'b010, 32'h0, v);
		chk(v, 32'hffffffff);
		regr(4'hd, v);
		chk(v, 32'h4);
		regw(4'hf, 32'h8);
		pci(3'b011, 32'h0000d00d, v);
		pci(3'b011, 32'h0000d00e, v);
		chk(32'(st[mq_pkg::ST_RETRY]), 32'h1);
		idle();
		chk(mem[BASE + 3 * QS], 32'h0000d00d);
		regr(4'he, v);
		chk(v, 32'h4);
		rd(mq_pkg::A_STATUS, st);
		chk(32'(st[mq_pkg::ST_FULL]), 32'h1);
		pci(3'b011, 32'h0000d00f, v);
		chk(32'(st[mq_pkg::ST_RETRY]), 32'h1);
		idle();
		chk(stores, 32'h2);
		regw(mq_pkg::RS_SIZE, 32'h1);
		regw(4'hb, 32'h100);
		pci(3'b101, 32'h0000a5a4, v);
		chk(32'(st[mq_pkg::ST_DISC]), 32'h1);
		idle();
		chk(mem[BASE + 32'h00008000 + 32'h4], 32'h0000a5a4);
		conclude();
	end
endmodule // message_queue_port_unit_bench

// [testbench/mq_chk.sv]
// Checker on the queue port link between the host end and the queue unit.
// Assumes it sees the link signals directly, all in the one core clock domain.
`timescale 1ns/10ps
module mq_chk (
	input wire logic CLOCK,
	input wire logic SYS_RST,
	input wire logic pci_req,
	input wire logic pci_write,
	input wire logic pci_port,
	input wire logic pci_burst,
	input wire logic pci_done,
	input wire logic pci_retry,
	input wire logic pci_disc,
	input wire logic [31:0] pci_rdata,
	input wire logic reg_we,
	input wire logic [3:0] reg_sel,
	input wire logic [31:0] reg_wdata,
	input wire logic [31:0] reg_rdata,
	input wire logic cpu_post_irq,
	input wire logic cpu_full_irq,
	input wire logic pci_inta
);
	// Cycles since the last accepted write per port; reset saturates so no event looks recent.
	logic [7:0] in_age_r;
	logic [7:0] out_age_r;
	always_ff @(posedge CLOCK) begin
		if (SYS_RST) in_age_r <= 8'hff;
		else if (pci_done && pci_write && !pci_port) in_age_r <= 8'h00;
		else if (in_age_r != 8'hff) in_age_r <= in_age_r + 8'h01;
	end
	always_ff @(posedge CLOCK) begin
		if (SYS_RST) out_age_r <= 8'hff;
		else if (pci_done && pci_write && pci_port) out_age_r <= 8'h00;
		else if (out_age_r != 8'hff) out_age_r <= out_age_r + 8'h01;
	end
	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (SYS_RST);
	disc_with_done_a: assert property (pci_disc |-> pci_done && pci_burst)
		else $error("disconnect outside a finished burst");
	burst_disc_a: assert property (pci_req && pci_burst && pci_done |-> pci_disc)
		else $error("burst finished without disconnect");
	post_irq_due_a: assert property (pci_done && pci_write && !pci_port |-> ##[1:100] cpu_post_irq)
		else $error("inbound post gave no processor interrupt");
	post_irq_cause_a: assert property (cpu_post_irq |-> in_age_r < 8'h64)
		else $error("processor post interrupt without an inbound write");
	full_irq_cause_a: assert property (cpu_full_irq |-> out_age_r < 8'h64)
		else $error("full interrupt without an outbound write");
	rdata_hold_a: assert property ($changed(pci_rdata) |-> pci_done && !pci_write)
		else $error("port read data moved outside a read completion");
	mask_quiet_a: assert property (reg_we && reg_sel == mq_pkg::RS_MASK && reg_wdata[0] |-> ##3 !pci_inta)
		else $error("masked PCI interrupt still high");
	base_readback_a: assert property (reg_we && reg_sel == mq_pkg::RS_BASE |-> ##2 reg_rdata == $past(reg_wdata, 2))
		else $error("queue region base readback wrong");
	cover property (pci_retry);
	cover property (pci_disc);
	cover property ($rose(pci_inta));
	cover property (cpu_full_irq);
endmodule // mq_chk
